// File: shared/ppr_consts.svh
// Offsets, reset values and timing counts of the port-pin block
`ifndef PPR_CONSTS_SVH
`define PPR_CONSTS_SVH
`define PPR_OFF_P2 12'h000
`define PPR_OFF_P3 12'h004
`define PPR_OFF_PM2 12'h008
`define PPR_OFF_PM3 12'h00C
`define PPR_OFF_IRQF 12'h010
`define PPR_OFF_IRQM 12'h014
`define PPR_OFF_STAT 12'h018
`define PPR_RST_PM 8'hFF
`define PPR_RST_MASK 8'h03
`define PPR_BIT_IRQA 1
`define PPR_BIT_IRQB 2
`define PPR_BIT_P2_SECOND 2
`define PPR_BIT_P2_THIRD 3
`define PPR_BIT_P3_SHARED 4
`define PPR_OPT_WAIT_CYC 4'd4
`endif

// File: shared/ppr_pkg.sv
// Types of the port-pin block
package ppr_pkg;
  typedef enum logic [2:0] {
    PPR_HELD = 3'b001,
    PPR_OPTION = 3'b010,
    PPR_RUN = 3'b100
  } ppr_state_t;
endpackage

// File: logic/ppr_sync.sv
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ns
module ppr_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= INIT;
      dout <= INIT;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// File: logic/ppr_port_pins.sv
// Port 2 and 3 pin logic with reset pulls, shared reset pin and APB
// Overview of operation
// - During reset, pull down port-2 second pin and third pin.
// - During reset, the shared reset pin is pulled up internally.
// - Option byte chooses shared pin as reset input or input port bit.
// - Option read after release; shared pin low keeps device in reset, except once running in port mode.
// - Output-mode level change on the two irq pins sets their flag.
// - Bit instructions read and rewrite the whole port byte.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "ppr_consts.svh"
module ppr_port_pins
  import ppr_pkg::*;
#(
  parameter int OPT_WAIT = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic option_port_mode,
  input wire logic [7:0] port2_in,
  output logic [7:0] port2_out,
  output logic [7:0] port2_oe,
  output logic [7:0] port2_pulldown,
  input wire logic [7:0] port3_in,
  output logic [7:0] port3_out,
  output logic [7:0] port3_oe,
  output logic reset_pin_pullup,
  output logic core_reset_n,
  output logic irq
);
  logic [7:0] p2_sync, p3_sync;
  logic opt_sync;
  logic [7:0] port2_latch, port3_latch, port2_direction, port3_direction;
  logic [7:0] interrupt_request_flags, interrupt_mask_flags;
  logic port_use;
  ppr_state_t state;
  logic [3:0] wait_cnt;
  logic wr, rd;
  logic [7:0] next_port2_pins, next_port3_pins;
  logic irq_capable_pin_a, irq_capable_pin_b;
  logic prev_a, prev_b, set_a, set_b;
  logic [7:0] irq_set;
  logic reset_shared_input_pin;

  ppr_sync #(.WIDTH(8), .INIT(8'h00)) u_sync2 (
    .pclk(pclk), .presetn(presetn), .din(port2_in), .dout(p2_sync));
  ppr_sync #(.WIDTH(9), .INIT(9'h1_10)) u_sync3 (
    .pclk(pclk), .presetn(presetn), .din({option_port_mode, port3_in}),
    .dout({opt_sync, p3_sync}));

  assign reset_shared_input_pin = p3_sync[`PPR_BIT_P3_SHARED];

  // Release sequence: wait while shared pin is high (hold while low), read option, then run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PPR_HELD;
      wait_cnt <= 4'd0;
      port_use <= 1'b0;
    end else begin
      case (state)
        PPR_HELD: begin
          state <= PPR_OPTION;
          wait_cnt <= 4'd0;
        end
        PPR_OPTION: begin
          if (!reset_shared_input_pin) begin
            wait_cnt <= 4'd0;
          end else if (wait_cnt == 4'(OPT_WAIT - 1)) begin
            port_use <= opt_sync;
            state <= PPR_RUN;
          end else begin
            wait_cnt <= wait_cnt + 4'd1;
          end
        end
        PPR_RUN: begin
          if (!port_use && !reset_shared_input_pin) begin
            state <= PPR_OPTION;
            wait_cnt <= 4'd0;
          end
        end
        default: state <= PPR_HELD;
      endcase
    end
  end

  assign core_reset_n = (state == PPR_RUN);
  assign reset_pin_pullup = !presetn || !port_use;

  always_comb begin
    port2_pulldown = 8'h00;
    if (!presetn) begin
      port2_pulldown[`PPR_BIT_P2_SECOND] = 1'b1;
      port2_pulldown[`PPR_BIT_P2_THIRD] = 1'b1;
    end
  end

  assign wr = psel && penable && pwrite && core_reset_n;
  assign rd = psel && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !core_reset_n;

  // Pin value reads: output pins read latch, inputs read the pin
  assign next_port2_pins = (port2_latch & ~port2_direction) |
                           (p2_sync & port2_direction);
  assign next_port3_pins = (port3_latch & ~port3_direction) |
                           (p3_sync & port3_direction);

  // Whole-byte writes; input-mode latches take what software wrote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port2_latch <= 8'h00;
      port3_latch <= 8'h00;
      port2_direction <= `PPR_RST_PM;
      port3_direction <= `PPR_RST_PM;
      interrupt_mask_flags <= `PPR_RST_MASK;
    end else if (wr) begin
      case (paddr)
        `PPR_OFF_P2: port2_latch <= pwdata[7:0];
        `PPR_OFF_P3: port3_latch <= pwdata[7:0];
        `PPR_OFF_PM2: port2_direction <= pwdata[7:0];
        `PPR_OFF_PM3: port3_direction <= pwdata[7:0];
        `PPR_OFF_IRQM: interrupt_mask_flags <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  assign port2_out = port2_latch;
  assign port3_out = port3_latch;
  assign port2_oe = core_reset_n ? ~port2_direction : 8'h00;
  assign port3_oe = core_reset_n ?
                    (~port3_direction & ~(8'h01 << `PPR_BIT_P3_SHARED)) :
                    8'h00;

  // Level of the irq pins: latch in output mode, synchronised pin in input mode
  assign irq_capable_pin_a = port2_direction[1] ? p2_sync[1] : port2_latch[1];
  assign irq_capable_pin_b = port3_direction[2] ? p3_sync[2] : port3_latch[2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
    end else begin
      prev_a <= irq_capable_pin_a;
      prev_b <= irq_capable_pin_b;
    end
  end
  assign set_a = core_reset_n && (prev_a != irq_capable_pin_a);
  assign set_b = core_reset_n && (prev_b != irq_capable_pin_b);
  always_comb begin
    irq_set = 8'h00;
    irq_set[`PPR_BIT_IRQA-1] = set_a;
    irq_set[`PPR_BIT_IRQB-1] = set_b;
  end

  // Sticky flags, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_request_flags <= 8'h00;
    end else begin
      interrupt_request_flags <= (interrupt_request_flags &
        ~((wr && paddr == `PPR_OFF_IRQF) ? pwdata[7:0] : 8'h00)) |
        irq_set;
    end
  end
  assign irq = |(interrupt_request_flags & ~interrupt_mask_flags);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      case (paddr)
        `PPR_OFF_P2: prdata <= {24'h00_0000, next_port2_pins};
        `PPR_OFF_P3: prdata <= {24'h00_0000, next_port3_pins};
        `PPR_OFF_PM2: prdata <= {24'h00_0000, port2_direction};
        `PPR_OFF_PM3: prdata <= {24'h00_0000, port3_direction};
        `PPR_OFF_IRQF: prdata <= {24'h00_0000, interrupt_request_flags};
        `PPR_OFF_IRQM: prdata <= {24'h00_0000, interrupt_mask_flags};
        `PPR_OFF_STAT: prdata <= {29'h0000_0000, port_use, core_reset_n,
                                  reset_shared_input_pin};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  held_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == PPR_OPTION && !reset_shared_input_pin) |=> !core_reset_n)
    else $error("left reset with shared pin low");
  flag_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_a |=> interrupt_request_flags[0])
    else $error("pin a change did not set flag");
  flag_sets_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_b |=> interrupt_request_flags[1])
    else $error("pin b change did not set flag");
  masked_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_mask_flags == 8'hFF) |-> !irq)
    else $error("irq while all masked");
  pull_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    port2_pulldown == 8'h00)
    else $error("pull-down after reset");
  option_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(core_reset_n) |-> $past(reset_shared_input_pin, 1))
    else $error("run entered with pin low");
  byte_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `PPR_OFF_P2) |=> port2_latch == $past(pwdata[7:0]))
    else $error("port byte not rewritten");
  pullup_a: assert property (@(posedge pclk) disable iff (!presetn)
    !port_use |-> reset_pin_pullup)
    else $error("reset pin pull-up missing");
endmodule

// File: sim/ppr_port_pins_tb.sv
// Self-checking bench for the port-pin block
`timescale 1ns/1ns
`include "ppr_consts.svh"
module ppr_port_pins_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic option_port_mode = 1'b0;
  logic [7:0] port2_in = 8'h00;
  logic [7:0] port3_in = 8'h10;
  logic [31:0] prdata;
  logic pready, pslverr, reset_pin_pullup, core_reset_n, irq;
  logic [7:0] port2_out, port2_oe, port2_pulldown, port3_out, port3_oe;
  int miscompares = 0;
  int n_compared = 0;
  always #10 pclk = ~pclk;
  ppr_port_pins #(.OPT_WAIT(4)) u_ppr_port_pins (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .option_port_mode(option_port_mode),
    .port2_in(port2_in), .port2_out(port2_out), .port2_oe(port2_oe),
    .port2_pulldown(port2_pulldown), .port3_in(port3_in),
    .port3_out(port3_out), .port3_oe(port3_oe),
    .reset_pin_pullup(reset_pin_pullup), .core_reset_n(core_reset_n),
    .irq(irq));
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("[ERR] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, a, d, v, e);
  endtask
  task automatic rchk(input string what, input logic [11:0] a,
      input logic [31:0] exp);
    logic [31:0] v;
    logic e;
    apb(1'b0, a, 32'h0, v, e);
    chk(what, v, exp);
  endtask
  task automatic do_reset(input logic mode, input logic pin);
    presetn <= 1'b0;
    option_port_mode <= mode;
    port3_in[4] <= pin;
    repeat (4) @(posedge pclk);
    chk("pulldown", {24'h0, port2_pulldown}, 32'h0000_000c);
    chk("pullup", {31'h0, reset_pin_pullup}, 32'h1);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("pulldown off", {24'h0, port2_pulldown}, 32'h0);
  endtask
  task automatic wait_core(input logic exp);
    int n = 0;
    while (core_reset_n !== exp && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("core reset", {31'h0, core_reset_n}, {31'h0, exp});
  endtask
  initial begin
    #(20 * 20000);
    miscompares++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    logic [31:0] r, w, p, v;
    logic e;
    logic [7:0] m;
    void'($urandom(6));
    do_reset(1'b0, 1'b1);
    wait_core(1'b1);
    rchk("stat", `PPR_OFF_STAT, 32'h0000_0003);
    rchk("irq mask", `PPR_OFF_IRQM, 32'h0000_0003);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      r = (i == 0) ? 32'h0000_00f0 : $urandom_range(255);
      w = $urandom_range(255);
      p = $urandom_range(255);
      port2_in <= p[7:0];
      wr(`PPR_OFF_PM2, r);
      wr(`PPR_OFF_P2, w);
      repeat (3) @(posedge pclk);
      chk("port2 oe", {24'h0, port2_oe}, ~r & 32'h0000_00ff);
      chk("port2 out", {24'h0, port2_out}, w);
      rchk("port2 mixed", `PPR_OFF_P2, (w & ~r) | (p & r));
      wr(`PPR_OFF_PM2, 32'h0);
      rchk("port2 latch", `PPR_OFF_P2, w);
    end
    $display("test port byte done");
    for (int k = 0; k < 2; k++) begin
      m = (k == 0) ? 8'h02 : 8'h04;
      wr(`PPR_OFF_IRQM, 32'h0000_0003);
      wr(k ? `PPR_OFF_PM3 : `PPR_OFF_PM2, {24'h0, ~m});
      wr(k ? `PPR_OFF_P3 : `PPR_OFF_P2, 32'h0);
      repeat (3) @(posedge pclk);
      chk("port3 oe", {24'h0, port3_oe}, k ? 32'h4 : 32'h0);
      wr(`PPR_OFF_IRQF, 32'h0000_0003);
      wr(k ? `PPR_OFF_P3 : `PPR_OFF_P2, {24'h0, m});
      repeat (3) @(posedge pclk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      chk("port3 out", {24'h0, port3_out}, k ? 32'h4 : 32'h0);
      rchk("flag set", `PPR_OFF_IRQF, 32'h1 << k);
      wr(`PPR_OFF_IRQM, 32'h0000_0003 & ~(32'h1 << k));
      chk("irq on", {31'h0, irq}, 32'h1);
      wr(`PPR_OFF_IRQF, 32'h1 << k);
      rchk("flag clear", `PPR_OFF_IRQF, 32'h0);
      chk("irq off", {31'h0, irq}, 32'h0);
    end
    $display("test interrupt flags done");
    do_reset(1'b0, 1'b0);
    repeat (30) @(posedge pclk);
    chk("held", {31'h0, core_reset_n}, 32'h0);
    apb(1'b1, `PPR_OFF_PM2, 32'h0, v, e);
    chk("refused", {31'h0, e}, 32'h1);
    port3_in[4] <= 1'b1;
    wait_core(1'b1);
    port3_in[4] <= 1'b0;
    wait_core(1'b0);
    do_reset(1'b1, 1'b1);
    wait_core(1'b1);
    port3_in[4] <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("port run", {31'h0, core_reset_n}, 32'h1);
    chk("pullup off", {31'h0, reset_pin_pullup}, 32'h0);
    rchk("stat port", `PPR_OFF_STAT, 32'h0000_0006);
    port3_in[4] <= 1'b1;
    repeat (3) @(posedge pclk);
    rchk("port3 pin", `PPR_OFF_P3, 32'h0000_0010);
    $display("test shared pin done");
    report_and_stop();
  end
endmodule
